// file: verilog/gcr_regs.sv
// Register bank for pin control, fast clock calibration and slot data hold.
// Assumes the serial control port delivers decoded reads and writes here.
//
// Behaviour
// - Bit 1 of the pin config register enables pin 0's input buffer and resets to zero.
// - Bit 6 of the pin config register enables pin 1's output driver, which drives only while set.
// - The pin 1 source select at bit 6 of the calibration register matters only while pin 1 is enabled.
// - Source select 0 drives pin 1 low and 1 drives it with the front end power-down signal.
// - Writing one to calibration start at bit 5 while it holds zero and the clock gate bit is one begins the fast-to-reference clock ratio calculation.
// - The computed ratio is placed in the ratio field of register 0x0a for the host to read.
// - While the slot B hold bit at bit 2 is one, slot B data registers do not update.
// - While the slot A hold bit at bit 1 is one, slot A data registers do not update.
// - With a hold bit at zero, that slot keeps taking new results, and zero is its reset value.
// - The fast clock runs for calibration only while the clock gate bit at bit 0 is one.
module gcr_regs #(
  parameter int CH          = 4,
  parameter int DW          = 16,
  parameter int REF_PERIODS = gcr_pkg::RefPeriods
) (
  // Clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             sys_rst_i,
  // Register port
  input  wire logic [7:0]       reg_addr_i,
  input  wire logic             reg_wr_i,
  input  wire logic [15:0]      reg_wdata_i,
  input  wire logic             reg_rd_i,
  output logic      [15:0]      reg_rdata_o,
  output logic                  reg_rvalid_o,
  // General-purpose pin 0
  input  wire logic             pin0_i,
  output logic                  pin0_in_o,
  // General-purpose pin 1
  input  wire logic             afe_powerdown_i,
  output logic                  pin1_o,
  output logic                  pin1_oe_o,
  // Fast clock calibration
  input  wire logic             fast_tick_i,
  input  wire logic             ref_tick_i,
  output logic                  fast_clock_run_o,
  output logic                  cal_busy_o,
  // Slot results
  input  wire logic             slot_a_valid_i,
  input  wire logic [CH*DW-1:0] slot_a_data_i,
  input  wire logic             slot_b_valid_i,
  input  wire logic [CH*DW-1:0] slot_b_data_i,
  output logic      [CH*DW-1:0] slot_a_out_o,
  output logic      [CH*DW-1:0] slot_b_out_o
);
  // Control bits
  logic pin0_input_enable,    next_pin0_input_enable;
  logic pin1_output_enable,   next_pin1_output_enable;
  logic pin1_source_select,   next_pin1_source_select;
  logic fast_clock_cal_start, next_fast_clock_cal_start;
  logic slot_a_hold,          next_slot_a_hold;
  logic slot_b_hold,          next_slot_b_hold;
  logic fast_clock_gate_enable, next_fast_clock_gate_enable;
  // Read path and pins
  logic [15:0] rdata,  next_rdata;
  logic        rvalid, next_rvalid;
  logic        pin1,   next_pin1;
  logic        pin1_oe, next_pin1_oe;
  logic        pin0_in, next_pin0_in;
  // Helper inputs and outputs
  logic [1:0][CH*DW-1:0] slot_data;
  logic [1:0][CH*DW-1:0] slot_new;
  logic [1:0]            slot_valid;

  gcr_cal_if  cal_bus ();
  gcr_hold_if hold_bus ();

  // Address decode, shared by the write and read paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // Register write path
  always_comb begin
    next_pin0_input_enable      = pin0_input_enable;
    next_pin1_output_enable     = pin1_output_enable;
    next_pin1_source_select     = pin1_source_select;
    next_fast_clock_cal_start   = fast_clock_cal_start;
    next_slot_a_hold            = slot_a_hold;
    next_slot_b_hold            = slot_b_hold;
    next_fast_clock_gate_enable = fast_clock_gate_enable;
    if (reg_wr_i) begin
      // Reserved bits are dropped and hold no state
      if (hit(reg_addr_i, gcr_pkg::PinCfgAddr)) begin
        next_pin0_input_enable  = reg_wdata_i[gcr_pkg::Pin0IeBit];
        next_pin1_output_enable = reg_wdata_i[gcr_pkg::Pin1OeBit];
      end
      if (hit(reg_addr_i, gcr_pkg::CalCtlAddr)) begin
        next_pin1_source_select   = reg_wdata_i[gcr_pkg::Pin1SelBit];
        next_fast_clock_cal_start = reg_wdata_i[gcr_pkg::CalStartBit];
      end
      if (hit(reg_addr_i, gcr_pkg::HoldAddr)) begin
        next_slot_b_hold            = reg_wdata_i[gcr_pkg::HoldBBit];
        next_slot_a_hold            = reg_wdata_i[gcr_pkg::HoldABit];
        next_fast_clock_gate_enable = reg_wdata_i[gcr_pkg::GateBit];
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      pin0_input_enable      <= gcr_pkg::RstBit;
      pin1_output_enable     <= gcr_pkg::RstBit;
      pin1_source_select     <= gcr_pkg::RstBit;
      fast_clock_cal_start   <= gcr_pkg::RstBit;
      slot_a_hold            <= gcr_pkg::RstBit;
      slot_b_hold            <= gcr_pkg::RstBit;
      fast_clock_gate_enable <= gcr_pkg::RstBit;
    end else begin
      pin0_input_enable      <= next_pin0_input_enable;
      pin1_output_enable     <= next_pin1_output_enable;
      pin1_source_select     <= next_pin1_source_select;
      fast_clock_cal_start   <= next_fast_clock_cal_start;
      slot_a_hold            <= next_slot_a_hold;
      slot_b_hold            <= next_slot_b_hold;
      fast_clock_gate_enable <= next_fast_clock_gate_enable;
    end
  end

  // Register read path: data one cycle after the read strobe
  always_comb begin
    next_rdata  = rdata;
    next_rvalid = reg_rd_i;
    if (reg_rd_i) begin
      next_rdata = 16'h0000;
      if (hit(reg_addr_i, gcr_pkg::RatioAddr)) begin
        next_rdata[gcr_pkg::RatioWidth-1:0] = cal_bus.ratio;
      end
      if (hit(reg_addr_i, gcr_pkg::PinCfgAddr)) begin
        next_rdata[gcr_pkg::Pin0IeBit] = pin0_input_enable;
        next_rdata[gcr_pkg::Pin1OeBit] = pin1_output_enable;
      end
      if (hit(reg_addr_i, gcr_pkg::CalCtlAddr)) begin
        next_rdata[gcr_pkg::Pin1SelBit]  = pin1_source_select;
        next_rdata[gcr_pkg::CalStartBit] = fast_clock_cal_start;
      end
      if (hit(reg_addr_i, gcr_pkg::HoldAddr)) begin
        next_rdata[gcr_pkg::HoldBBit] = slot_b_hold;
        next_rdata[gcr_pkg::HoldABit] = slot_a_hold;
        next_rdata[gcr_pkg::GateBit]  = fast_clock_gate_enable;
      end
    end
  end

  // Pin drive
  always_comb begin
    next_pin0_in = pin0_i & pin0_input_enable;
    next_pin1_oe = pin1_output_enable;
    next_pin1    = 1'b0;
    if (pin1_output_enable && pin1_source_select) begin
      next_pin1 = afe_powerdown_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      rdata   <= 16'h0000;
      rvalid  <= 1'b0;
      pin1    <= 1'b0;
      pin1_oe <= 1'b0;
      pin0_in <= 1'b0;
    end else begin
      rdata   <= next_rdata;
      rvalid  <= next_rvalid;
      pin1    <= next_pin1;
      pin1_oe <= next_pin1_oe;
      pin0_in <= next_pin0_in;
    end
  end

  assign reg_rdata_o  = rdata;
  assign reg_rvalid_o = rvalid;
  assign pin1_o       = pin1;
  assign pin1_oe_o    = pin1_oe;
  assign pin0_in_o    = pin0_in;

  // Calibration engine
  assign cal_bus.start    = fast_clock_cal_start;
  assign cal_bus.gate     = fast_clock_gate_enable;
  assign fast_clock_run_o = fast_clock_gate_enable;
  assign cal_busy_o       = cal_bus.busy;

  gcr_clk_cal #(
    .REF_PERIODS (REF_PERIODS)
  ) u_cal (
    .sys_clk_i   (sys_clk_i),
    .sys_rst_i   (sys_rst_i),
    .fast_tick_i (fast_tick_i),
    .ref_tick_i  (ref_tick_i),
    .cal         (cal_bus)
  );

  // Slot data registers
  assign hold_bus.hold[gcr_pkg::SlotA] = slot_a_hold;
  assign hold_bus.hold[gcr_pkg::SlotB] = slot_b_hold;
  assign slot_valid = {slot_b_valid_i, slot_a_valid_i};
  assign slot_new   = {slot_b_data_i, slot_a_data_i};

  gcr_slot_hold #(
    .CH (CH),
    .DW (DW)
  ) u_hold (
    .sys_clk_i   (sys_clk_i),
    .sys_rst_i   (sys_rst_i),
    .new_valid_i (slot_valid),
    .new_data_i  (slot_new),
    .data_o      (slot_data),
    .hc          (hold_bus)
  );

  assign slot_a_out_o = slot_data[gcr_pkg::SlotA];
  assign slot_b_out_o = slot_data[gcr_pkg::SlotB];

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  a_pin0_gated_in: assert property (
    !pin0_input_enable |=> !pin0_in_o)
    else $error("pin 0 input passed with buffer disabled");
  a_pin1_oe_follow: assert property (
    (reg_wr_i && hit(reg_addr_i, gcr_pkg::PinCfgAddr))
      |=> ##1 pin1_oe_o == $past(reg_wdata_i[gcr_pkg::Pin1OeBit], 2))
    else $error("pin 1 enable did not follow the write");
  a_pin1_low_sel: assert property (
    (pin1_output_enable && !pin1_source_select) |=> !pin1_o)
    else $error("pin 1 not low with source zero");
  a_pin1_pd_drive: assert property (
    (pin1_output_enable && pin1_source_select) |=> pin1_o == $past(afe_powerdown_i))
    else $error("pin 1 not carrying power-down");
  a_cal_start_run: assert property (
    (reg_wr_i && hit(reg_addr_i, gcr_pkg::CalCtlAddr) && reg_wdata_i[gcr_pkg::CalStartBit]
      && !fast_clock_cal_start && fast_clock_gate_enable && !cal_bus.busy && !cal_bus.done)
      |=> ##1 cal_busy_o)
    else $error("calibration did not begin on start");
  a_ratio_readback: assert property (
    (reg_rd_i && hit(reg_addr_i, gcr_pkg::RatioAddr))
      |=> reg_rvalid_o && reg_rdata_o[gcr_pkg::RatioWidth-1:0] == $past(cal_bus.ratio))
    else $error("ratio read returned wrong value");
  a_gate_clock_run: assert property (
    (reg_wr_i && hit(reg_addr_i, gcr_pkg::HoldAddr))
      |=> fast_clock_run_o == $past(reg_wdata_i[gcr_pkg::GateBit]))
    else $error("fast clock run does not follow gate bit");
  a_unmapped_zero: assert property (
    (reg_rd_i && !hit(reg_addr_i, gcr_pkg::RatioAddr) && !hit(reg_addr_i, gcr_pkg::PinCfgAddr)
      && !hit(reg_addr_i, gcr_pkg::CalCtlAddr) && !hit(reg_addr_i, gcr_pkg::HoldAddr))
      |=> reg_rdata_o == 16'h0000)
    else $error("unmapped read not zero");

  // Read port answers exactly once per strobe and holds its data between reads
  a_rvalid_pulse: assert property (
    reg_rd_i |=> reg_rvalid_o)
    else $error("read strobe gave no answer");
  a_rvalid_quiet: assert property (
    !reg_rd_i |=> !reg_rvalid_o)
    else $error("read answer without a read strobe");
  a_rdata_holds: assert property (
    !reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved between reads");

  // Control bits take the written value on the next edge
  a_pin0_ie_write: assert property (
    (reg_wr_i && hit(reg_addr_i, gcr_pkg::PinCfgAddr))
      |=> pin0_input_enable == $past(reg_wdata_i[gcr_pkg::Pin0IeBit]))
    else $error("pin 0 input enable did not take the write");
  a_pin0_pass: assert property (
    pin0_input_enable |=> pin0_in_o == $past(pin0_i))
    else $error("pin 0 input not passed with buffer enabled");
  a_pin1_off_low: assert property (
    !pin1_output_enable |=> !pin1_o)
    else $error("pin 1 source acted while output disabled");
  a_cal_ctl_write: assert property (
    (reg_wr_i && hit(reg_addr_i, gcr_pkg::CalCtlAddr))
      |=> fast_clock_cal_start == $past(reg_wdata_i[gcr_pkg::CalStartBit])
          && pin1_source_select == $past(reg_wdata_i[gcr_pkg::Pin1SelBit]))
    else $error("calibration control did not take the write");
  a_hold_bits_write: assert property (
    (reg_wr_i && hit(reg_addr_i, gcr_pkg::HoldAddr))
      |=> slot_b_hold == $past(reg_wdata_i[gcr_pkg::HoldBBit])
          && slot_a_hold == $past(reg_wdata_i[gcr_pkg::HoldABit]))
    else $error("hold bits did not take the write");
  a_busy_needs_gate: assert property (
    (cal_busy_o && !fast_clock_gate_enable) |=> !cal_busy_o)
    else $error("calibration kept counting with the fast clock off");

  // Reserved bits always read back as zero
  a_hold_reserved: assert property (
    (reg_rd_i && hit(reg_addr_i, gcr_pkg::HoldAddr))
      |=> reg_rdata_o[15:gcr_pkg::HoldBBit+1] == '0)
    else $error("hold register reserved bits read nonzero");
  a_cal_reserved: assert property (
    (reg_rd_i && hit(reg_addr_i, gcr_pkg::CalCtlAddr))
      |=> reg_rdata_o[15:gcr_pkg::Pin1SelBit+1] == '0 && reg_rdata_o[gcr_pkg::CalStartBit-1:0] == '0)
    else $error("calibration register reserved bits read nonzero");
  a_ratio_upper_zero: assert property (
    (reg_rd_i && hit(reg_addr_i, gcr_pkg::RatioAddr))
      |=> reg_rdata_o[15:gcr_pkg::RatioWidth] == '0)
    else $error("ratio register upper bits read nonzero");
endmodule

// file: verilog/gcr_pkg.sv
// Package for the pin, clock-calibration and data-hold register bank.
// Assumes a 16-bit register port with byte-wide addresses.
package gcr_pkg;
  // Register offsets
  localparam logic [7:0] RatioAddr  = 8'h0a;
  localparam logic [7:0] PinCfgAddr = 8'h4f;
  localparam logic [7:0] CalCtlAddr = 8'h50;
  localparam logic [7:0] HoldAddr   = 8'h5f;
  // Field positions
  localparam int Pin0IeBit  = 1;
  localparam int Pin1OeBit  = 6;
  localparam int Pin1SelBit = 6;
  localparam int CalStartBit = 5;
  localparam int HoldBBit   = 2;
  localparam int HoldABit   = 1;
  localparam int GateBit    = 0;
  // Reset values of the implemented bits
  localparam logic RstBit = 1'b0;
  // Calibration defaults
  localparam int RatioWidth = 12;
  localparam int RefPeriods = 1;
  // Slot indices
  localparam int SlotA = 0;
  localparam int SlotB = 1;
  // Calibration states, Gray along idle, count, done
  typedef enum logic [1:0] {
    CAL_IDLE  = 2'b00,
    CAL_COUNT = 2'b01,
    CAL_DONE  = 2'b11
  } gcr_cal_state_type;
endpackage

// file: verilog/gcr_ifs.sv
// Carriers between the register bank and its two helpers.
// Assumes everything runs on the one system clock.
interface gcr_cal_if;
  logic                             start;
  logic                             gate;
  logic                             busy;
  logic                             done;
  logic [gcr_pkg::RatioWidth-1:0]   ratio;
  modport ctl (output start, output gate, input busy, input done, input ratio);
  modport eng (input start, input gate, output busy, output done, output ratio);
endinterface

interface gcr_hold_if;
  logic [1:0] hold;
  modport ctl (output hold);
  modport eng (input hold);
endinterface

// file: verilog/gcr_clk_cal.sv
// Clock ratio engine: counts fast-clock ticks over reference periods.
// Assumes tick inputs are one-cycle pulses synchronous to sys_clk_i.
module gcr_clk_cal #(
  parameter int REF_PERIODS = gcr_pkg::RefPeriods
) (
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic sys_rst_i,
  // Tick sources
  input  wire logic fast_tick_i,
  input  wire logic ref_tick_i,
  // Control
  gcr_cal_if.eng    cal
);
  localparam int RW = gcr_pkg::RatioWidth;
  gcr_pkg::gcr_cal_state_type state, next_state;
  logic          start_q, next_start_q;
  logic [RW-1:0] cnt, next_cnt, ratio, next_ratio;
  logic [15:0]   refs, next_refs;
  logic          fast_en;

  // Fast ticks count only while the fast clock is gated on
  assign fast_en = fast_tick_i & cal.gate;

  always_comb begin
    next_state   = state;
    next_cnt     = cnt;
    next_ratio   = ratio;
    next_refs    = refs;
    next_start_q = cal.start;
    case (state)
      gcr_pkg::CAL_IDLE: begin
        // Only a fresh 0-to-1 write of start begins a run
        if (cal.start && !start_q && cal.gate) begin
          next_state = gcr_pkg::CAL_COUNT;
          next_cnt   = '0;
          next_refs  = '0;
        end
      end
      gcr_pkg::CAL_COUNT: begin
        if (!cal.gate || !cal.start) begin
          next_state = gcr_pkg::CAL_IDLE;
        end else begin
          if (fast_en) begin
            next_cnt = cnt + RW'(1);
          end
          if (ref_tick_i) begin
            next_refs = refs + 16'h0001;
            if (refs == 16'(REF_PERIODS - 1)) begin
              next_ratio = fast_en ? cnt + RW'(1) : cnt;
              next_state = gcr_pkg::CAL_DONE;
            end
          end
        end
      end
      gcr_pkg::CAL_DONE: begin
        if (!cal.start) begin
          next_state = gcr_pkg::CAL_IDLE;
        end
      end
      default: next_state = gcr_pkg::CAL_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      state   <= gcr_pkg::CAL_IDLE;
      cnt     <= '0;
      ratio   <= '0;
      refs    <= '0;
      start_q <= 1'b0;
    end else begin
      state   <= next_state;
      cnt     <= next_cnt;
      ratio   <= next_ratio;
      refs    <= next_refs;
      start_q <= next_start_q;
    end
  end

  assign cal.ratio = ratio;
  assign cal.busy  = (state == gcr_pkg::CAL_COUNT);
  assign cal.done  = (state == gcr_pkg::CAL_DONE);

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  a_cal_needs_edge: assert property (
    (state == gcr_pkg::CAL_IDLE && (start_q || !cal.gate)) |=> state == gcr_pkg::CAL_IDLE)
    else $error("calibration began without a fresh start under gate");
  a_cal_gate_stop: assert property (
    (state == gcr_pkg::CAL_COUNT && !cal.gate) |=> state == gcr_pkg::CAL_IDLE && $stable(cnt))
    else $error("count kept running with fast clock off");
endmodule

// file: verilog/gcr_slot_hold.sv
// Slot data registers, frozen per slot while that slot's hold bit is set.
// Assumes new results arrive as one-cycle valid pulses per slot.
module gcr_slot_hold #(
  parameter int CH = 4,
  parameter int DW = 16
) (
  // Clock and reset
  input  wire logic                        sys_clk_i,
  input  wire logic                        sys_rst_i,
  // New results per slot
  input  wire logic [1:0]                  new_valid_i,
  input  wire logic [1:0][CH*DW-1:0]       new_data_i,
  // Held registers
  output logic      [1:0][CH*DW-1:0]       data_o,
  // Hold control
  gcr_hold_if.eng                          hc
);
  logic [1:0][CH*DW-1:0] data, next_data;

  for (genvar s = 0; s < 2; s++) begin : g_slot
    always_comb begin
      next_data[s] = data[s];
      if (new_valid_i[s] && !hc.hold[s]) begin
        next_data[s] = new_data_i[s];
      end
    end
    always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
        data[s] <= '0;
      end else begin
        data[s] <= next_data[s];
      end
    end
  end

  assign data_o = data;

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  a_hold_b_frozen: assert property (
    hc.hold[gcr_pkg::SlotB] |=> $stable(data[gcr_pkg::SlotB]))
    else $error("slot B data changed while held");
  a_hold_a_frozen: assert property (
    hc.hold[gcr_pkg::SlotA] |=> $stable(data[gcr_pkg::SlotA]))
    else $error("slot A data changed while held");
  a_slot_updates: assert property (
    (new_valid_i[gcr_pkg::SlotA] && !hc.hold[gcr_pkg::SlotA])
      |=> data[gcr_pkg::SlotA] == $past(new_data_i[gcr_pkg::SlotA]))
    else $error("slot A data missed an update");
endmodule

// file: tb/gcr_host_model.sv
// Host processor model that drives the decoded register port of the bank.
// Assumes the bench clock and a read answer registered on the edge that takes the read.
module gcr_host_model (
  // Clock
  input  wire logic        sys_clk_i,
  // Register port
  output logic      [7:0]  reg_addr_o,
  output logic             reg_wr_o,
  output logic      [15:0] reg_wdata_o,
  output logic             reg_rd_o,
  input  wire logic [15:0] reg_rdata_i,
  input  wire logic        reg_rvalid_i
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    reg_addr_o  = 8'h00;
    reg_wr_o    = 1'b0;
    reg_wdata_o = 16'h0000;
    reg_rd_o    = 1'b0;
  end

  // Callers keep reserved bits zero except where a probe is intended
  task automatic write_reg(input logic [7:0] addr, input logic [15:0] data);
    @(posedge sys_clk_i);
    reg_addr_o  <= addr;
    reg_wdata_o <= data;
    reg_wr_o    <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_o    <= 1'b0;
    reg_addr_o  <= ~addr;
    reg_wdata_o <= ~data;
  endtask

  // Answer is taken once the edge that accepted the read has settled
  task automatic read_reg(input logic [7:0] addr, output logic [15:0] data, output logic ok);
    @(posedge sys_clk_i);
    reg_addr_o <= addr;
    reg_rd_o   <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_o   <= 1'b0;
    reg_addr_o <= ~addr;
    #1;
    ok   = reg_rvalid_i;
    data = reg_rdata_i;
  endtask
endmodule

// file: tb/tb_top.sv
// Self-checking bench for the pin, clock-calibration and data-hold registers.
// Assumes the host model drives the register port and the bench drives all else.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RefN = 2;

  logic        sys_clk_i;
  logic        sys_rst_i;
  logic [7:0]  reg_addr;
  logic        reg_wr;
  logic [15:0] reg_wdata;
  logic        reg_rd;
  logic [15:0] reg_rdata_o;
  logic        reg_rvalid_o;
  logic        pin0_i;
  logic        pin0_in_o;
  logic        afe_powerdown_i;
  logic        pin1_o;
  logic        pin1_oe_o;
  logic        fast_tick_i;
  logic        ref_tick_i;
  logic        fast_clock_run_o;
  logic        cal_busy_o;
  logic        slot_a_valid_i;
  logic        slot_b_valid_i;
  logic [63:0] slot_a_data_i;
  logic [63:0] slot_b_data_i;
  logic [63:0] slot_a_out_o;
  logic [63:0] slot_b_out_o;
  int          bad_count;
  int          n_checks;
  int          cycles;

  gcr_regs #(.CH(4), .DW(16), .REF_PERIODS(RefN)) gcr_regs_inst (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(reg_addr), .reg_wr_i(reg_wr), .reg_wdata_i(reg_wdata), .reg_rd_i(reg_rd),
    .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
    .pin0_i(pin0_i), .pin0_in_o(pin0_in_o),
    .afe_powerdown_i(afe_powerdown_i), .pin1_o(pin1_o), .pin1_oe_o(pin1_oe_o),
    .fast_tick_i(fast_tick_i), .ref_tick_i(ref_tick_i),
    .fast_clock_run_o(fast_clock_run_o), .cal_busy_o(cal_busy_o),
    .slot_a_valid_i(slot_a_valid_i), .slot_a_data_i(slot_a_data_i),
    .slot_b_valid_i(slot_b_valid_i), .slot_b_data_i(slot_b_data_i),
    .slot_a_out_o(slot_a_out_o), .slot_b_out_o(slot_b_out_o)
  );

  gcr_host_model gcr_host_model_inst (
    .sys_clk_i(sys_clk_i), .reg_addr_o(reg_addr), .reg_wr_o(reg_wr),
    .reg_wdata_o(reg_wdata), .reg_rd_o(reg_rd),
    .reg_rdata_i(reg_rdata_o), .reg_rvalid_i(reg_rvalid_o)
  );

  always #20 sys_clk_i = ~sys_clk_i;

  task automatic complete_run();
    if (bad_count == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask

  task automatic wr(input logic [7:0] addr, input logic [15:0] data);
    gcr_host_model_inst.write_reg(addr, data);
  endtask

  task automatic rd(input logic [7:0] addr, input logic [15:0] exp);
    logic [15:0] data;
    logic        ok;
    gcr_host_model_inst.read_reg(addr, data, ok);
    check(ok, 1'b1, "read answer");
    check(data, exp, "read data");
  endtask

  task automatic test_reset();
    rd(gcr_pkg::PinCfgAddr, 16'h0000);
    rd(gcr_pkg::CalCtlAddr, 16'h0000);
    rd(gcr_pkg::HoldAddr, 16'h0000);
    rd(gcr_pkg::RatioAddr, 16'h0000);
    rd(8'h33, 16'h0000);
    check(pin1_oe_o, 1'b0, "oe after reset");
  endtask

  task automatic test_pins();
    @(posedge sys_clk_i);
    pin0_i <= 1'b1;
    wr(gcr_pkg::PinCfgAddr, 16'h0002);
    step(3);
    check(pin0_in_o, 1'b1, "pin0 enabled");
    rd(gcr_pkg::PinCfgAddr, 16'h0002);
    wr(gcr_pkg::PinCfgAddr, 16'h0040);
    step(3);
    check(pin0_in_o, 1'b0, "pin0 disabled");
    check(pin1_oe_o, 1'b1, "pin1 driving");
    check(pin1_o, 1'b0, "pin1 low source");
    rd(gcr_pkg::PinCfgAddr, 16'h0040);
    @(posedge sys_clk_i);
    afe_powerdown_i <= 1'b1;
    wr(gcr_pkg::CalCtlAddr, 16'h0040);
    step(3);
    check(pin1_o, 1'b1, "pin1 follows power-down");
    @(posedge sys_clk_i);
    afe_powerdown_i <= 1'b0;
    step(2);
    check(pin1_o, 1'b0, "pin1 follows power-down low");
    @(posedge sys_clk_i);
    afe_powerdown_i <= 1'b1;
    wr(gcr_pkg::PinCfgAddr, 16'h0000);
    step(3);
    check(pin1_oe_o, 1'b0, "pin1 released");
    check(pin1_o, 1'b0, "select ignored when released");
    wr(gcr_pkg::CalCtlAddr, 16'hffdf);
    rd(gcr_pkg::CalCtlAddr, 16'h0040);
    wr(gcr_pkg::RatioAddr, 16'h0fff);
    rd(gcr_pkg::RatioAddr, 16'h0000);
    wr(gcr_pkg::CalCtlAddr, 16'h0000);
  endtask

  // Last reference tick carries one fast tick, so the count is n plus one
  task automatic cal_run(input int n);
    int i;
    wr(gcr_pkg::CalCtlAddr, 16'h0020);
    i = 0;
    while (cal_busy_o !== 1'b1 && i < 10) begin
      step(1);
      i++;
    end
    check(cal_busy_o, 1'b1, "calibration busy");
    for (i = 0; i < n; i++) begin
      @(posedge sys_clk_i);
      fast_tick_i <= 1'b1;
      @(posedge sys_clk_i);
      fast_tick_i <= 1'b0;
    end
    for (i = 0; i < RefN; i++) begin
      @(posedge sys_clk_i);
      ref_tick_i  <= 1'b1;
      fast_tick_i <= (i == RefN - 1);
      @(posedge sys_clk_i);
      ref_tick_i  <= 1'b0;
      fast_tick_i <= 1'b0;
    end
    step(1);
    check(cal_busy_o, 1'b0, "calibration finished");
    rd(gcr_pkg::RatioAddr, 16'(n + 1));
  endtask

  task automatic test_cal();
    wr(gcr_pkg::HoldAddr, 16'h0001);
    step(1);
    check(fast_clock_run_o, 1'b1, "fast clock on");
    cal_run(5);
    wr(gcr_pkg::CalCtlAddr, 16'h0020);
    step(4);
    check(cal_busy_o, 1'b0, "start without clear");
    wr(gcr_pkg::CalCtlAddr, 16'h0000);
    cal_run(3);
    wr(gcr_pkg::CalCtlAddr, 16'h0000);
    wr(gcr_pkg::HoldAddr, 16'h0000);
    step(1);
    check(fast_clock_run_o, 1'b0, "fast clock off");
    wr(gcr_pkg::CalCtlAddr, 16'h0020);
    step(4);
    check(cal_busy_o, 1'b0, "start with gate off");
    wr(gcr_pkg::CalCtlAddr, 16'h0000);
    // Abort a run by switching the fast clock off; the old ratio must survive
    wr(gcr_pkg::HoldAddr, 16'h0001);
    wr(gcr_pkg::CalCtlAddr, 16'h0020);
    step(1);
    check(cal_busy_o, 1'b1, "run before abort");
    wr(gcr_pkg::HoldAddr, 16'h0000);
    step(2);
    check(cal_busy_o, 1'b0, "gate off aborts");
    wr(gcr_pkg::HoldAddr, 16'h0001);
    wr(gcr_pkg::CalCtlAddr, 16'h0020);
    step(4);
    check(cal_busy_o, 1'b0, "start rewritten without clear");
    rd(gcr_pkg::RatioAddr, 16'h0004);
    wr(gcr_pkg::CalCtlAddr, 16'h0000);
    wr(gcr_pkg::HoldAddr, 16'h0000);
  endtask

  task automatic push(input logic [15:0] k);
    @(posedge sys_clk_i);
    slot_a_valid_i <= 1'b1;
    slot_b_valid_i <= 1'b1;
    slot_a_data_i  <= {4{k}};
    slot_b_data_i  <= ~{4{k}};
    @(posedge sys_clk_i);
    slot_a_valid_i <= 1'b0;
    slot_b_valid_i <= 1'b0;
    slot_a_data_i  <= ~{4{k}};
    slot_b_data_i  <= {4{k}};
    #1;
  endtask

  task automatic test_hold();
    push(16'h1a2b);
    check(slot_a_out_o, {4{16'h1a2b}}, "slot a free");
    wr(gcr_pkg::HoldAddr, 16'h0002);
    push(16'h3c4d);
    check(slot_a_out_o, {4{16'h1a2b}}, "slot a held");
    check(slot_b_out_o, ~{4{16'h3c4d}}, "slot b free");
    wr(gcr_pkg::HoldAddr, 16'h0004);
    push(16'h5e6f);
    check(slot_a_out_o, {4{16'h5e6f}}, "slot a resumed");
    check(slot_b_out_o, ~{4{16'h3c4d}}, "slot b held");
    rd(gcr_pkg::HoldAddr, 16'h0004);
    wr(gcr_pkg::HoldAddr, 16'hfff8);
    rd(gcr_pkg::HoldAddr, 16'h0000);
    push(16'h7081);
    check(slot_b_out_o, ~{4{16'h7081}}, "slot b resumed");
  endtask

  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      complete_run();
    end
  end

  initial begin
    sys_clk_i       = 1'b0;
    sys_rst_i       = 1'b1;
    pin0_i          = 1'b0;
    afe_powerdown_i = 1'b0;
    fast_tick_i     = 1'b0;
    ref_tick_i      = 1'b0;
    slot_a_valid_i  = 1'b0;
    slot_b_valid_i  = 1'b0;
    slot_a_data_i   = 64'h0;
    slot_b_data_i   = 64'h0;
    bad_count       = 0;
    n_checks        = 0;
    cycles          = 0;
    repeat (2) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    test_reset();
    test_pins();
    test_cal();
    test_hold();
    complete_run();
  end
endmodule
